/* File: hdl/tcm_timer.sv */
// Added by the designer: the AHB-Lite slave port and the register offsets.
`default_nettype none

module tcm_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        timer_tick,
    input  wire logic [3:0]  flag_service,
    input  wire logic        capture_pin,
    output logic [3:0]       flags,
    output logic [1:0]       pin_out,
    output logic [1:0]       pin_oe_n
);
    import tcm_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] capt;
        logic [3:0]  mode;
        logic [3:0]  act;
        logic        cap_rise;
        logic [1:0]  oc;
        logic [3:0]  flags;
        logic [1:0]  port_val;
        logic [1:0]  dir;
        logic        block;
        logic        cap_prev;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
        logic [1:0]  pin_out;
        logic [1:0]  pin_oe_n;
    } tcm_state_t;

    tcm_state_t r;
    tcm_state_t next_r;

    logic       cap_level;
    logic       wr_ctrl;
    logic       wr_force;
    logic       wr_count;
    logic       wr_cmpa;
    logic       wr_cmpb;
    logic       wr_capt;
    logic       wr_flags;
    logic       wr_port;
    logic       rd_req;
    logic       pwm;
    logic       ctc_a;
    logic       ctc_c;
    logic       top_hit;
    logic [1:0] match;
    logic [1:0] force_oc;
    logic       cap_edge;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic [1:0] act_c;

    // ****************************************************
    // Capture pin synchroniser
    // ****************************************************
    tcm_sync3 u_cap_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (capture_pin),
        .level    (cap_level)
    );

    // ****************************************************
    // Bus decode; writes land in the data phase
    // ****************************************************
    assign rd_req   = hsel && hready && htrans[1] && !hwrite;
    assign wr_ctrl  = r.wr_pend && (r.wr_addr == TCM_OFF_CTRL);
    assign wr_force = r.wr_pend && (r.wr_addr == TCM_OFF_FORCE);
    assign wr_count = r.wr_pend && (r.wr_addr == TCM_OFF_COUNT);
    assign wr_cmpa  = r.wr_pend && (r.wr_addr == TCM_OFF_CMPA);
    assign wr_cmpb  = r.wr_pend && (r.wr_addr == TCM_OFF_CMPB);
    assign wr_capt  = r.wr_pend && (r.wr_addr == TCM_OFF_CAPT);
    assign wr_flags = r.wr_pend && (r.wr_addr == TCM_OFF_FLAGS);
    assign wr_port  = r.wr_pend && (r.wr_addr == TCM_OFF_PORT);

    // ****************************************************
    // Mode decode and compare
    // ****************************************************
    assign ctc_a = (r.mode == TCM_MODE_CTC_A);
    assign ctc_c = (r.mode == TCM_MODE_CTC_C);
    assign pwm   = !(r.mode == TCM_MODE_NORMAL || ctc_a || ctc_c);

    // Direct compare against live TOP, so a TOP below the count is missed
    assign top_hit = ctc_a ? (r.count == r.cmp_a) :
                     ctc_c ? (r.count == r.capt) : 1'b0;

    // A counter write masks matches for the following tick
    assign match[0] = timer_tick && !r.block && (r.count == r.cmp_a);
    assign match[1] = timer_tick && !r.block && (r.count == r.cmp_b);

    assign force_oc = (wr_force && !pwm) ? hwdata[1:0] : 2'h0;

    // Capture input is not gated by action bits at all
    assign cap_edge = !ctc_c && (r.cap_rise ? (cap_level && !r.cap_prev)
                                            : (!cap_level && r.cap_prev));

    assign flag_set[TCM_FLG_OVF]  = timer_tick && (r.count == TCM_MAX);
    assign flag_set[TCM_FLG_CMPA] = match[0];
    assign flag_set[TCM_FLG_CMPB] = match[1];
    assign flag_set[TCM_FLG_CAPT] = cap_edge
                                    || (ctc_c && timer_tick && !r.block && top_hit);

    assign flag_clr = (wr_flags ? hwdata[3:0] : 4'h0) | flag_service;

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        next_r           = r;
        act_c            = TCM_ACT_NONE;
        next_r.hreadyout = 1'b1;
        next_r.hresp     = 1'b0;

        // Software registers
        if (wr_ctrl) begin
            next_r.mode     = hwdata[TCM_CTRL_MODE_LSB +: 4];
            next_r.act      = hwdata[TCM_CTRL_ACT_LSB +: 4];
            next_r.cap_rise = hwdata[TCM_CTRL_EDGE_BIT];
        end
        if (wr_cmpa) begin
            next_r.cmp_a = hwdata[15:0];
        end
        if (wr_cmpb) begin
            next_r.cmp_b = hwdata[15:0];
        end
        if (wr_capt) begin
            next_r.capt = hwdata[15:0];
        end
        if (wr_port) begin
            next_r.port_val = hwdata[TCM_PORT_VAL_LSB +: 2];
            next_r.dir      = hwdata[TCM_PORT_DIR_LSB +: 2];
        end

        // Counting; action bits play no part here
        if (timer_tick) begin
            next_r.block = 1'b0;
            if (top_hit && !r.block) begin
                next_r.count = TCM_BOTTOM;
            end else begin
                next_r.count = r.count + TCM_ONE;
            end
        end
        if (wr_count) begin
            next_r.count = hwdata[15:0];
            next_r.block = 1'b1;
        end

        // Capture
        next_r.cap_prev = cap_level;
        if (cap_edge) begin
            next_r.capt = r.count;
        end

        // Set wins over clear
        next_r.flags = (r.flags & ~flag_clr) | flag_set;

        // Output state per channel; action is sampled at match time
        for (int c = 0; c < 2; c++) begin
            act_c = r.act[2*c +: 2];
            if (!pwm && (match[c] || force_oc[c])) begin
                unique case (act_c)
                    TCM_ACT_TOGGLE: next_r.oc[c] = !r.oc[c];
                    TCM_ACT_CLEAR:  next_r.oc[c] = 1'b0;
                    TCM_ACT_SET:    next_r.oc[c] = 1'b1;
                    TCM_ACT_NONE:   next_r.oc[c] = r.oc[c];
                endcase
            end
            if (next_r.act[2*c +: 2] != TCM_ACT_NONE) begin
                next_r.pin_out[c] = next_r.oc[c];
            end else begin
                next_r.pin_out[c] = next_r.port_val[c];
            end
            next_r.pin_oe_n[c] = !next_r.dir[c];
        end

        // Address phase capture
        next_r.wr_pend = hsel && hready && htrans[1] && hwrite;
        if (hsel && hready && htrans[1]) begin
            next_r.wr_addr = {haddr[7:2], 2'h0};
        end

        // Read data from the post-write view, so back-to-back reads see writes
        if (rd_req) begin
            next_r.hrdata = 32'h0000_0000;
            unique case ({haddr[7:2], 2'h0})
                TCM_OFF_CTRL:  next_r.hrdata = {23'h0, next_r.cap_rise, next_r.act, next_r.mode};
                TCM_OFF_COUNT: next_r.hrdata = {16'h0, next_r.count};
                TCM_OFF_CMPA:  next_r.hrdata = {16'h0, next_r.cmp_a};
                TCM_OFF_CMPB:  next_r.hrdata = {16'h0, next_r.cmp_b};
                TCM_OFF_CAPT:  next_r.hrdata = {16'h0, next_r.capt};
                TCM_OFF_FLAGS: next_r.hrdata = {28'h0, next_r.flags};
                TCM_OFF_PORT:  next_r.hrdata = {26'h0, next_r.oc, next_r.dir, next_r.port_val};
                default:       next_r.hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r           <= '0;
            r.oc        <= TCM_OC_RST;
            r.hreadyout <= 1'b1;
            r.pin_oe_n  <= TCM_OE_N_RST;
        end else begin
            r <= next_r;
        end
    end

    assign hreadyout = r.hreadyout;
    assign hrdata    = r.hrdata;
    assign hresp     = r.hresp;
    assign flags     = r.flags;
    assign pin_out   = r.pin_out;
    assign pin_oe_n  = r.pin_oe_n;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_ovf_wrap: assert property (
        (timer_tick && !wr_count && r.count == TCM_MAX && !top_hit)
        |=> (r.count == TCM_BOTTOM) && r.flags[TCM_FLG_OVF])
        else $error("counter did not wrap with overflow flag");

    chk_ctc_clear: assert property (
        (timer_tick && !wr_count && ctc_a && !r.block && r.count == r.cmp_a)
        |=> (r.count == TCM_BOTTOM) && r.flags[TCM_FLG_CMPA])
        else $error("clear-on-match did not clear counter");

    chk_cmp_flag: assert property (
        (timer_tick && !r.block && r.count == r.cmp_b)
        |=> r.flags[TCM_FLG_CMPB])
        else $error("compare B flag missing after match");

    chk_tick_hold: assert property (
        (!timer_tick && !wr_count) |=> $stable(r.count))
        else $error("counter moved without timer tick");

    chk_pin_override: assert property (
        (r.act[1:0] != TCM_ACT_NONE) |-> (pin_out[0] == r.oc[0]))
        else $error("pin A not driven by output state");

    chk_pin_dir: assert property (
        pin_oe_n[0] == !r.dir[0] && pin_oe_n[1] == !r.dir[1])
        else $error("output enable does not follow direction");

    chk_force_toggle: assert property (
        (force_oc[0] && r.act[1:0] == TCM_ACT_TOGGLE && !timer_tick && !wr_count)
        |=> (r.oc[0] != $past(r.oc[0])) && $stable(r.count))
        else $error("force did not toggle output immediately");

    chk_act_zero: assert property (
        (r.act[3:2] == TCM_ACT_NONE) |=> $stable(r.oc[1]))
        else $error("output B changed with action none");

endmodule

`default_nettype wire

/* File: shared/tcm_pkg.sv */
`default_nettype none

package tcm_pkg;

    // ****************************************************
    // Register map (byte addresses)
    // ****************************************************
    localparam logic [7:0] TCM_OFF_CTRL  = 8'h00;
    localparam logic [7:0] TCM_OFF_FORCE = 8'h04;
    localparam logic [7:0] TCM_OFF_COUNT = 8'h08;
    localparam logic [7:0] TCM_OFF_CMPA  = 8'h0C;
    localparam logic [7:0] TCM_OFF_CMPB  = 8'h10;
    localparam logic [7:0] TCM_OFF_CAPT  = 8'h14;
    localparam logic [7:0] TCM_OFF_FLAGS = 8'h18;
    localparam logic [7:0] TCM_OFF_PORT  = 8'h1C;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int TCM_CTRL_MODE_LSB = 0;
    localparam int TCM_CTRL_ACT_LSB  = 4;
    localparam int TCM_CTRL_EDGE_BIT = 8;
    localparam int TCM_FLG_OVF       = 0;
    localparam int TCM_FLG_CMPA      = 1;
    localparam int TCM_FLG_CMPB      = 2;
    localparam int TCM_FLG_CAPT      = 3;
    localparam int TCM_PORT_VAL_LSB  = 0;
    localparam int TCM_PORT_DIR_LSB  = 2;
    localparam int TCM_PORT_OC_LSB   = 4;

    // ****************************************************
    // Waveform modes and output actions
    // ****************************************************
    localparam logic [3:0] TCM_MODE_NORMAL = 4'h0;
    localparam logic [3:0] TCM_MODE_CTC_A  = 4'h4;
    localparam logic [3:0] TCM_MODE_CTC_C  = 4'hC;

    localparam logic [1:0] TCM_ACT_NONE   = 2'h0;
    localparam logic [1:0] TCM_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TCM_ACT_CLEAR  = 2'h2;
    localparam logic [1:0] TCM_ACT_SET    = 2'h3;

    // ****************************************************
    // Counter limits and reset values
    // ****************************************************
    localparam logic [15:0] TCM_MAX        = 16'hFFFF;
    localparam logic [15:0] TCM_BOTTOM     = 16'h0000;
    localparam logic [15:0] TCM_ONE        = 16'h0001;
    localparam logic [1:0]  TCM_OC_RST     = 2'h0;
    localparam logic [1:0]  TCM_OE_N_RST   = 2'h3;

endpackage

`default_nettype wire

/* File: hdl/tcm_sync3.sv */
`default_nettype none

module tcm_sync3 (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic async_in,
    output logic      level
);
    import tcm_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } tcm_sync_t;

    tcm_sync_t r;
    tcm_sync_t next_r;

    // ****************************************************
    // Three stages; level moves only when stage two and three agree
    // ****************************************************
    always_comb begin
        next_r    = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.lvl = r.s3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.lvl;

endmodule

`default_nettype wire

/* File: verification/tcm_pin_model.sv */
`default_nettype none

module tcm_pin_model (
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe_n,
    input  wire logic       ext_level,
    output logic [1:0]      pad,
    output logic            capture_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************
    // Port pins with pull-ups
    // ****************************************************
    // A pin left as input floats to its pull-up, never the last driven value
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pad[i] = pin_oe_n[i] ? 1'b1 : pin_out[i];
        end
    end

    // External event source seen on the capture input
    assign capture_pin = ext_level;
endmodule

`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tcm_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        timer_tick;
    logic [3:0]  flag_service;
    logic        capture_pin;
    logic        ext_level;
    logic [3:0]  flags;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe_n;
    logic [1:0]  pad;
    int          failures;
    int          cmp_count;

    tcm_timer i_tcm_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .timer_tick(timer_tick), .flag_service(flag_service),
        .capture_pin(capture_pin), .flags(flags), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    tcm_pin_model i_tcm_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
        .pad(pad), .capture_pin(capture_pin));

    // ****************************************************
    // Bus and timer helpers
    // ****************************************************
    task automatic end_sim();
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin
            failures++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(name, exp, q);
    endtask

    task automatic ticks(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge hclk);
        timer_tick <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] act, input logic [3:0] mode);
        return {24'h000000, 2'h0, act, mode};
    endfunction

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_reset();
        rdc("ctrl", TCM_OFF_CTRL, 32'h00000000);
        rdc("port", TCM_OFF_PORT, 32'h00000000);
        rdc("unmapped", 8'h20, 32'h00000000);
        chk("oe_pad", 32'h0000000F, {28'h0000000, pin_oe_n, pad});
        chk("bus_resp", 32'h00000002, {30'h00000000, hreadyout, hresp});
    endtask

    task automatic t_normal();
        wr(TCM_OFF_CMPA, 32'h00008000);
        wr(TCM_OFF_CMPB, 32'h00008000);
        wr(TCM_OFF_COUNT, 32'h0000FFFE);
        repeat (4) @(posedge hclk);
        rdc("count_idle", TCM_OFF_COUNT, 32'h0000FFFE);
        ticks(1);
        rdc("count_max", TCM_OFF_COUNT, 32'h0000FFFF);
        rdc("ovf_early", TCM_OFF_FLAGS, 32'h00000000);
        ticks(2);
        rdc("count_wrap", TCM_OFF_COUNT, 32'h00000001);
        rdc("ovf_set", TCM_OFF_FLAGS, 32'h00000001);
        chk("flags", 32'h00000001, {28'h0000000, flags});
        flag_service <= 4'h1;
        @(posedge hclk);
        flag_service <= 4'h0;
        rdc("ovf_serviced", TCM_OFF_FLAGS, 32'h00000000);
    endtask

    task automatic t_ctc_a();
        wr(TCM_OFF_PORT, 32'h00000004);
        wr(TCM_OFF_CMPA, 32'h00000002);
        wr(TCM_OFF_COUNT, 32'h00000000);
        wr(TCM_OFF_CTRL, ctl(TCM_ACT_TOGGLE, TCM_MODE_CTC_A));
        ticks(3);
        rdc("ctc_count", TCM_OFF_COUNT, 32'h00000000);
        rdc("ctc_flags", TCM_OFF_FLAGS, 32'h00000002);
        rdc("toggle_hi", TCM_OFF_PORT, 32'h00000014);
        chk("pad_a", 32'h00000001, {31'h00000000, pad[0]});
        ticks(3);
        rdc("toggle_lo", TCM_OFF_PORT, 32'h00000004);
        wr(TCM_OFF_CTRL, ctl(TCM_ACT_SET, TCM_MODE_CTC_A));
        rdc("set_wait", TCM_OFF_PORT, 32'h00000004);
        ticks(3);
        rdc("set_match", TCM_OFF_PORT, 32'h00000014);
        wr(TCM_OFF_CTRL, ctl(TCM_ACT_NONE, TCM_MODE_CTC_A));
        ticks(3);
        rdc("none_match", TCM_OFF_PORT, 32'h00000014);
        chk("pin_port", 32'h00000000, {31'h00000000, pin_out[0]});
        wr(TCM_OFF_CTRL, ctl(TCM_ACT_CLEAR, TCM_MODE_CTC_A));
        ticks(3);
        rdc("clr_match", TCM_OFF_PORT, 32'h00000004);
        wr(TCM_OFF_FLAGS, 32'h00000002);
        rdc("cmpa_clr", TCM_OFF_FLAGS, 32'h00000000);
    endtask

    task automatic t_force();
        wr(TCM_OFF_PORT, 32'h00000000);
        wr(TCM_OFF_CTRL, ctl(TCM_ACT_SET, TCM_MODE_NORMAL));
        wr(TCM_OFF_CMPA, 32'h00000064);
        wr(TCM_OFF_COUNT, 32'h00000005);
        wr(TCM_OFF_FORCE, 32'h00000001);
        rdc("force_state", TCM_OFF_PORT, 32'h00000010);
        rdc("force_count", TCM_OFF_COUNT, 32'h00000005);
        rdc("force_flags", TCM_OFF_FLAGS, 32'h00000000);
        chk("oe_pad_off", 32'h00000003, {30'h00000000, pin_oe_n[0], pad[0]});
        wr(TCM_OFF_PORT, 32'h00000004);
        rdc("port_dir", TCM_OFF_PORT, 32'h00000014);
        chk("oe_pad_on", 32'h00000001, {30'h00000000, pin_oe_n[0], pad[0]});
        wr(TCM_OFF_CTRL, ctl(TCM_ACT_TOGGLE, TCM_MODE_NORMAL));
        wr(TCM_OFF_FORCE, 32'h00000001);
        rdc("force_tgl", TCM_OFF_PORT, 32'h00000004);
        ticks(3);
        rdc("count_act", TCM_OFF_COUNT, 32'h00000008);
        // Channel B: set on match at count 10, then clear its flag
        wr(TCM_OFF_CMPB, 32'h0000000A);
        wr(TCM_OFF_CTRL, 32'h000000C0);
        ticks(3);
        rdc("cmpb_val", TCM_OFF_CMPB, 32'h0000000A);
        rdc("cmpb_flag", TCM_OFF_FLAGS, 32'h00000004);
        rdc("set_b", TCM_OFF_PORT, 32'h00000024);
        chk("pin_b", 32'h00000001, {31'h00000000, pin_out[1]});
        wr(TCM_OFF_FLAGS, 32'h00000004);
        rdc("cmpb_clr", TCM_OFF_FLAGS, 32'h00000000);
        // PWM mode: force is ignored, counting goes on
        wr(TCM_OFF_CTRL, 32'h00000031);
        wr(TCM_OFF_FORCE, 32'h00000001);
        rdc("pwm_force", TCM_OFF_PORT, 32'h00000024);
        ticks(1);
        rdc("pwm_count", TCM_OFF_COUNT, 32'h0000000C);
    endtask

    task automatic t_capture();
        ext_level <= 1'b0;
        repeat (8) @(posedge hclk);
        rdc("capt_val", TCM_OFF_CAPT, 32'h0000000C);
        rdc("capt_flag", TCM_OFF_FLAGS, 32'h00000008);
        // Rising edge selected
        wr(TCM_OFF_FLAGS, 32'h00000008);
        wr(TCM_OFF_CTRL, 32'h00000100);
        wr(TCM_OFF_COUNT, 32'h00000020);
        ext_level <= 1'b1;
        repeat (8) @(posedge hclk);
        rdc("rise_val", TCM_OFF_CAPT, 32'h00000020);
        rdc("rise_flag", TCM_OFF_FLAGS, 32'h00000008);
        wr(TCM_OFF_FLAGS, 32'h00000008);
        wr(TCM_OFF_CAPT, 32'h00000003);
        wr(TCM_OFF_CTRL, ctl(TCM_ACT_NONE, TCM_MODE_CTC_C));
        wr(TCM_OFF_COUNT, 32'h00000000);
        ticks(4);
        rdc("top_count", TCM_OFF_COUNT, 32'h00000000);
        rdc("top_flag", TCM_OFF_FLAGS, 32'h00000008);
        wr(TCM_OFF_COUNT, 32'h00000005);
        ticks(1);
        rdc("missed_top", TCM_OFF_COUNT, 32'h00000006);
        wr(TCM_OFF_COUNT, 32'h0000FFFF);
        ticks(1);
        rdc("ctc_ovf", TCM_OFF_FLAGS, 32'h00000009);
        wr(TCM_OFF_CAPT, 32'h00000001);
        ticks(2);
        rdc("new_top", TCM_OFF_COUNT, 32'h00000000);
    endtask

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        timer_tick = 1'b0;
        flag_service = 4'h0;
        ext_level = 1'b1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_normal();
        t_ctc_a();
        t_force();
        t_capture();
        end_sim();
    end
endmodule

`default_nettype wire
